// [pkg/adc_seq_pkg.sv]
// Register map, field layout, reset values and modes of the channel sequencer
package adc_seq_pkg;

	localparam int SLOTS   = 16;
	localparam int SETUPS  = 8;
	localparam int IDX_W   = 6;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_STATUS     = 6'h00;
	localparam logic [5:0] IDX_CTRL       = 6'h01;
	localparam logic [5:0] IDX_DATA       = 6'h02;
	localparam logic [5:0] IDX_CHAN_FIRST = 6'h09;
	localparam logic [5:0] IDX_CFG_FIRST  = 6'h19;
	localparam logic [5:0] IDX_FILT_FIRST = 6'h21;
	localparam logic [5:0] IDX_OFFS_FIRST = 6'h29;
	localparam logic [5:0] IDX_GAIN_FIRST = 6'h31;
	localparam logic [5:0] IDX_END        = 6'h39;

	// Reset values
	localparam logic [15:0] CHAN_RST = 16'h8001;
	localparam logic [15:0] CFG_RST  = 16'h0860;
	localparam logic [23:0] FILT_RST = 24'h060180;
	localparam logic [23:0] OFFS_RST = 24'h800000;
	localparam logic [15:0] CTRL_RST = 16'h0000;

	// Channel slot fields
	localparam int CH_EN_BIT    = 15;
	localparam int CH_SETUP_LSB = 12;
	localparam int CH_POS_LSB   = 5;
	localparam int CH_NEG_LSB   = 0;

	// Setup configuration fields
	localparam int CFG_BIPOLAR       = 11;
	localparam int CFG_POS_REFIN_BUF = 8;
	localparam int CFG_NEG_REFIN_BUF = 7;
	localparam int CFG_POS_IN_BUF    = 6;
	localparam int CFG_NEG_IN_BUF    = 5;
	localparam int CFG_REFSEL_LSB    = 3;
	localparam int CFG_GAIN_LSB      = 0;

	// Control fields
	localparam int CTRL_REF_EN   = 0;
	localparam int CTRL_MODE_LSB = 2;

	// Reference source codes
	localparam logic [1:0] REF_EXT_ONE = 2'h0;
	localparam logic [1:0] REF_EXT_TWO = 2'h1;
	localparam logic [1:0] REF_INT     = 2'h2;

	// Highest gain code served by a single amplifier stage (gain 8)
	localparam logic [2:0] GAIN_ONE_STAGE_MAX = 3'h3;

	// Code with only the top bit set: zero input in bipolar coding
	localparam logic [23:0] MID_CODE = 24'h800000;

	// Operating modes of the sequencer
	typedef enum logic [3:0] {
		MODE_CONT     = 4'h0,
		MODE_IDLE     = 4'h1,
		MODE_ZCAL_INT = 4'h2,
		MODE_FCAL_INT = 4'h3,
		MODE_ZCAL_SYS = 4'h4,
		MODE_FCAL_SYS = 4'h5
	} mode_t;

endpackage : adc_seq_pkg

// [design/slot_scan.sv]
// Finder of the next enabled channel slot in ascending, wrapping order
`timescale 1ns/1ps
module slot_scan #(
	parameter int N = 16,
	parameter int W = 4
) (
	input  wire logic [N-1:0] en,
	input  wire logic [W-1:0] cur,
	output logic      [W-1:0] nxt,
	output logic              any
);

	logic [W-1:0] lo;
	logic [W-1:0] hi;
	logic         hi_found;

	// Lowest enabled slot, and lowest enabled slot above the current one
	always_comb
	begin
		lo = '0;
		hi = '0;
		hi_found = 1'b0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (en[i])
			begin
				lo = W'(i);
			end
			if (en[i] && (W'(i) > cur))
			begin
				hi = W'(i);
				hi_found = 1'b1;
			end
		end
		any = |en;
		nxt = hi_found ? hi : lo;
	end

endmodule : slot_scan

// [design/adc_seq_top.sv]
// Channel slot, setup and sequencing logic of a multi-channel converter
// Behaviour
// - Enabled slots are visited in ascending order, wrapping to the lowest.
// - Slot bit 15 enables the slot; only enabled slots join the sequence.
// - Each slot holds 5-bit positive and negative input selectors, any pin.
// - Eight setups exist; each slot points at one, setups may be shared.
// - Each setup owns config, filter, gain and offset; slot uses its setup.
// - Calibration overwrites offset or gain of the active slot's setup.
// - Selectors form differential, pseudo-differential or mixed inputs.
// - Input buffers follow the two buffer bits of the active setup.
// - Gain above one forces both input buffers on.
// - Gain 1 to 128; no amplifier stage at 1, one stage from 2 up to 8, both above.
// - Internal reference powered by control bit; routed out when powered and selected.
// - Setup reference field picks external one, external two or internal.
// - Setup bipolar bit chooses bipolar or unipolar range.
// - Unipolar is straight binary; bipolar is offset binary, zero at mid.
`timescale 1ns/1ps
module adc_seq_top #(
	parameter int          ADDR_W   = 8,
	parameter logic [23:0] GAIN_RST = 24'h500000
) (
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              conv_done,
	input  wire logic [23:0]       conv_raw,
	output logic                   conv_run,
	output logic                   cal_internal,
	output logic      [3:0]        active_slot,
	output logic      [4:0]        pos_input_sel,
	output logic      [4:0]        neg_input_sel,
	output logic                   pos_input_buf_en,
	output logic                   neg_input_buf_en,
	output logic                   pos_refin_buf_en,
	output logic                   neg_refin_buf_en,
	output logic      [2:0]        gain_select,
	output logic                   amp_stage1_en,
	output logic                   amp_stage2_en,
	output logic      [1:0]        ref_source,
	output logic                   int_ref_power,
	output logic                   ref_output_drive,
	output logic                   bipolar_mode,
	output logic      [23:0]       filter_word,
	output logic      [23:0]       offset_coef,
	output logic      [23:0]       gain_coef,
	output logic      [23:0]       result_data,
	output logic                   result_valid,
	output logic      [3:0]        result_slot
);

	////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [15:0][15:0] chan;
		logic [7:0][15:0]  cfg;
		logic [7:0][23:0]  filt;
		logic [7:0][23:0]  offs;
		logic [7:0][23:0]  gain;
		logic [15:0]       ctrl;
		logic [3:0]        slot;
		logic [31:0]       prdata;
		logic              pready;
		logic              pslverr;
		logic              run;
		logic              cal_int;
		logic [4:0]        pos_sel;
		logic [4:0]        neg_sel;
		logic              pbuf;
		logic              nbuf;
		logic              prbuf;
		logic              nrbuf;
		logic [2:0]        gsel;
		logic              st1;
		logic              st2;
		logic [1:0]        refsrc;
		logic              refpwr;
		logic              ref_output_pin;
		logic              bip;
		logic [23:0]       filtw;
		logic [23:0]       offc;
		logic [23:0]       gainc;
		logic [23:0]       res;
		logic              res_valid;
		logic [3:0]        res_slot;
	} state_t;

	state_t      s_q;
	state_t      s_d;
	logic [15:0] en;
	logic [3:0]  nxt;
	logic        any;

	////////////////////////////////////////////////////////////////////////////
	// Sequence order

	// Gather slot enable bits
	always_comb
	begin
		for (int i = 0; i < adc_seq_pkg::SLOTS; i++)
		begin
			en[i] = s_q.chan[i][adc_seq_pkg::CH_EN_BIT];
		end
	end

	slot_scan #(
		.N (adc_seq_pkg::SLOTS),
		.W (4)
	) u_scan (
		.en  (en),
		.cur (s_q.slot),
		.nxt (nxt),
		.any (any)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state

	logic [5:0]               idx;
	logic [5:0]               r_ch;
	logic [5:0]               r_cfg;
	logic [5:0]               r_flt;
	logic [5:0]               r_off;
	logic [5:0]               r_gn;
	logic [2:0]               su_q;
	logic [2:0]               su_d;
	logic [23:0]              corr;
	logic [15:0]              ch_d;
	logic [15:0]              cf_d;
	adc_seq_pkg::mode_t       mode;

	always_comb
	begin
		s_d = s_q;
		s_d.res_valid = 1'b0;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		idx = paddr[7:2];
		r_ch = idx - adc_seq_pkg::IDX_CHAN_FIRST;
		r_cfg = idx - adc_seq_pkg::IDX_CFG_FIRST;
		r_flt = idx - adc_seq_pkg::IDX_FILT_FIRST;
		r_off = idx - adc_seq_pkg::IDX_OFFS_FIRST;
		r_gn = idx - adc_seq_pkg::IDX_GAIN_FIRST;
		mode = adc_seq_pkg::mode_t'(s_q.ctrl[adc_seq_pkg::CTRL_MODE_LSB +: 4]);
		su_q = s_q.chan[s_q.slot][adc_seq_pkg::CH_SETUP_LSB +: 3];
		corr = conv_raw + adc_seq_pkg::MID_CODE - s_q.offs[su_q];

		// Setup phase: read data and error answer in the first access cycle
		if (psel && !penable)
		begin
			s_d.pready = 1'b1;
			s_d.prdata = 32'h0000_0000;
			if (paddr[1:0] != 2'h0 || idx >= adc_seq_pkg::IDX_END)
				s_d.pslverr = 1'b1;
			else if (idx == adc_seq_pkg::IDX_STATUS)
				s_d.prdata = {26'h0, s_q.cal_int, s_q.run, s_q.slot};
			else if (idx == adc_seq_pkg::IDX_CTRL)
				s_d.prdata = {16'h0, s_q.ctrl};
			else if (idx == adc_seq_pkg::IDX_DATA)
				s_d.prdata = {8'h00, s_q.res};
			else if (idx < adc_seq_pkg::IDX_CHAN_FIRST)
				s_d.pslverr = 1'b1;
			else if (idx < adc_seq_pkg::IDX_CFG_FIRST)
				s_d.prdata = {16'h0, s_q.chan[r_ch[3:0]]};
			else if (idx < adc_seq_pkg::IDX_FILT_FIRST)
				s_d.prdata = {16'h0, s_q.cfg[r_cfg[2:0]]};
			else if (idx < adc_seq_pkg::IDX_OFFS_FIRST)
				s_d.prdata = {8'h00, s_q.filt[r_flt[2:0]]};
			else if (idx < adc_seq_pkg::IDX_GAIN_FIRST)
				s_d.prdata = {8'h00, s_q.offs[r_off[2:0]]};
			else
				s_d.prdata = {8'h00, s_q.gain[r_gn[2:0]]};
			// Status and result words do not take writes
			if (pwrite && (idx == adc_seq_pkg::IDX_STATUS || idx == adc_seq_pkg::IDX_DATA))
				s_d.pslverr = 1'b1;
		end

		// Access phase: writes land on the edge that samples pready
		if (psel && penable && s_q.pready && pwrite && !s_q.pslverr)
		begin
			if (idx == adc_seq_pkg::IDX_CTRL)
				s_d.ctrl = pwdata[15:0];
			else if (idx >= adc_seq_pkg::IDX_CHAN_FIRST && idx < adc_seq_pkg::IDX_CFG_FIRST)
				s_d.chan[r_ch[3:0]] = pwdata[15:0];
			else if (idx >= adc_seq_pkg::IDX_CFG_FIRST && idx < adc_seq_pkg::IDX_FILT_FIRST)
				s_d.cfg[r_cfg[2:0]] = pwdata[15:0];
			else if (idx >= adc_seq_pkg::IDX_FILT_FIRST && idx < adc_seq_pkg::IDX_OFFS_FIRST)
				s_d.filt[r_flt[2:0]] = pwdata[23:0];
			else if (idx >= adc_seq_pkg::IDX_OFFS_FIRST && idx < adc_seq_pkg::IDX_GAIN_FIRST)
				s_d.offs[r_off[2:0]] = pwdata[23:0];
			else if (idx >= adc_seq_pkg::IDX_GAIN_FIRST)
				s_d.gain[r_gn[2:0]] = pwdata[23:0];
		end

		// End of a conversion from the modulator
		if (conv_done && s_q.run)
		begin
			case (mode)
				adc_seq_pkg::MODE_CONT:
				begin
					if (en[s_q.slot])
					begin
						s_d.res_valid = 1'b1;
						s_d.res_slot = s_q.slot;
						if (s_q.bip)
							s_d.res = corr ^ adc_seq_pkg::MID_CODE;
						else
							s_d.res = corr[23] ? 24'h000000 : {corr[22:0], 1'b0};
					end
					s_d.slot = nxt;
				end
				adc_seq_pkg::MODE_ZCAL_INT, adc_seq_pkg::MODE_ZCAL_SYS:
				begin
					s_d.offs[su_q] = conv_raw + adc_seq_pkg::MID_CODE;
					s_d.ctrl[adc_seq_pkg::CTRL_MODE_LSB +: 4] = adc_seq_pkg::MODE_IDLE;
				end
				adc_seq_pkg::MODE_FCAL_INT, adc_seq_pkg::MODE_FCAL_SYS:
				begin
					s_d.gain[su_q] = corr;
					s_d.ctrl[adc_seq_pkg::CTRL_MODE_LSB +: 4] = adc_seq_pkg::MODE_IDLE;
				end
				default:
				begin
					s_d.slot = s_q.slot;
				end
			endcase
		end

		// Analog controls of the slot active after this edge
		ch_d = s_d.chan[s_d.slot];
		su_d = ch_d[adc_seq_pkg::CH_SETUP_LSB +: 3];
		cf_d = s_d.cfg[su_d];
		mode = adc_seq_pkg::mode_t'(s_d.ctrl[adc_seq_pkg::CTRL_MODE_LSB +: 4]);
		s_d.run = (mode != adc_seq_pkg::MODE_IDLE) && any;
		s_d.cal_int = (mode == adc_seq_pkg::MODE_ZCAL_INT) ||
			(mode == adc_seq_pkg::MODE_FCAL_INT);
		s_d.pos_sel = ch_d[adc_seq_pkg::CH_POS_LSB +: 5];
		s_d.neg_sel = ch_d[adc_seq_pkg::CH_NEG_LSB +: 5];
		s_d.gsel = cf_d[adc_seq_pkg::CFG_GAIN_LSB +: 3];
		s_d.pbuf = cf_d[adc_seq_pkg::CFG_POS_IN_BUF];
		s_d.nbuf = cf_d[adc_seq_pkg::CFG_NEG_IN_BUF];
		if (s_d.gsel != 3'h0)
		begin
			s_d.pbuf = 1'b1;
			s_d.nbuf = 1'b1;
		end
		s_d.prbuf = cf_d[adc_seq_pkg::CFG_POS_REFIN_BUF];
		s_d.nrbuf = cf_d[adc_seq_pkg::CFG_NEG_REFIN_BUF];
		s_d.st1 = s_d.gsel != 3'h0;
		s_d.st2 = s_d.gsel > adc_seq_pkg::GAIN_ONE_STAGE_MAX;
		s_d.refsrc = cf_d[adc_seq_pkg::CFG_REFSEL_LSB +: 2];
		s_d.refpwr = s_d.ctrl[adc_seq_pkg::CTRL_REF_EN];
		s_d.ref_output_pin = s_d.refpwr && (s_d.refsrc == adc_seq_pkg::REF_INT);
		s_d.bip = cf_d[adc_seq_pkg::CFG_BIPOLAR];
		s_d.filtw = s_d.filt[su_d];
		s_d.offc = s_d.offs[su_d];
		s_d.gainc = s_d.gain[su_d];
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			s_q <= '0;
			for (int i = 0; i < adc_seq_pkg::SLOTS; i++)
				s_q.chan[i] <= (i == 0) ? adc_seq_pkg::CHAN_RST : 16'h0000;
			for (int i = 0; i < adc_seq_pkg::SETUPS; i++)
			begin
				s_q.cfg[i] <= adc_seq_pkg::CFG_RST;
				s_q.filt[i] <= adc_seq_pkg::FILT_RST;
				s_q.offs[i] <= adc_seq_pkg::OFFS_RST;
				s_q.gain[i] <= GAIN_RST;
			end
			s_q.ctrl <= adc_seq_pkg::CTRL_RST;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state
	assign prdata           = s_q.prdata;
	assign pready           = s_q.pready;
	assign pslverr          = s_q.pslverr;
	assign conv_run         = s_q.run;
	assign cal_internal     = s_q.cal_int;
	assign active_slot      = s_q.slot;
	assign pos_input_sel    = s_q.pos_sel;
	assign neg_input_sel    = s_q.neg_sel;
	assign pos_input_buf_en = s_q.pbuf;
	assign neg_input_buf_en = s_q.nbuf;
	assign pos_refin_buf_en = s_q.prbuf;
	assign neg_refin_buf_en = s_q.nrbuf;
	assign gain_select      = s_q.gsel;
	assign amp_stage1_en    = s_q.st1;
	assign amp_stage2_en    = s_q.st2;
	assign ref_source       = s_q.refsrc;
	assign int_ref_power    = s_q.refpwr;
	assign ref_output_drive = s_q.ref_output_pin;
	assign bipolar_mode     = s_q.bip;
	assign filter_word      = s_q.filtw;
	assign offset_coef      = s_q.offc;
	assign gain_coef        = s_q.gainc;
	assign result_data      = s_q.res;
	assign result_valid     = s_q.res_valid;
	assign result_slot      = s_q.res_slot;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	logic cont_q;
	assign cont_q = s_q.ctrl[5:2] == adc_seq_pkg::MODE_CONT;

	property p_seq_order;
		conv_done && conv_run && cont_q |=> active_slot == $past(nxt);
	endproperty
	a_seq_order: assert property (p_seq_order) else $error("slot order broken");

	property p_wrap_low;
		conv_done && conv_run && cont_q && nxt < active_slot
			|=> active_slot <= $past(active_slot);
	endproperty
	a_wrap_low: assert property (p_wrap_low) else $error("wrap went upward");

	property p_only_enabled;
		result_valid |-> $past(en[active_slot]) && result_slot == $past(active_slot);
	endproperty
	a_only_enabled: assert property (p_only_enabled) else $error("disabled slot converted");

	property p_selectors;
		// Derived outputs settle one edge after reset release
		!$past(sys_rst) |-> pos_input_sel == s_q.chan[active_slot][9:5]
			&& neg_input_sel == s_q.chan[active_slot][4:0];
	endproperty
	a_selectors: assert property (p_selectors) else $error("selector mismatch");

	property p_coef_source;
		!$past(sys_rst) |-> offset_coef == s_q.offs[s_q.chan[active_slot][14:12]];
	endproperty
	a_coef_source: assert property (p_coef_source) else $error("wrong setup coefficient");

	property p_force_buf;
		gain_select != 3'h0 |-> pos_input_buf_en && neg_input_buf_en && amp_stage1_en;
	endproperty
	a_force_buf: assert property (p_force_buf) else $error("buffers not forced");

	property p_stages;
		amp_stage2_en == (gain_select > 3'h3) && amp_stage1_en == (gain_select != 3'h0);
	endproperty
	a_stages: assert property (p_stages) else $error("amplifier stage mismatch");

	property p_ref_output_pin;
		ref_output_drive |-> int_ref_power && ref_source == 2'h2;
	endproperty
	a_ref_output_pin: assert property (p_ref_output_pin) else $error("reference routed unpowered");

	property p_zero_code;
		conv_done && conv_run && cont_q && conv_raw == 24'h000000 && offset_coef == 24'h800000
			&& bipolar_mode && en[active_slot] |=> result_data == 24'h800000;
	endproperty
	a_zero_code: assert property (p_zero_code) else $error("bipolar zero not mid code");

	property p_zcal;
		conv_done && conv_run && s_q.ctrl[5:2] == 4'h2
			|=> offset_coef == $past(conv_raw) + 24'h800000 ##1 !conv_run || !cal_internal;
	endproperty
	a_zcal: assert property (p_zcal) else $error("offset calibration not stored");

	property p_apb_answer;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("bus answer timing");

	c_result: cover property (result_valid);
	c_wrap: cover property (conv_done && conv_run && cont_q && nxt < active_slot);
	c_cal: cover property (conv_done && conv_run && cal_internal);

endmodule : adc_seq_top

// [bench/tb_adc_channel_setup_sequencer.sv]
// Self-checking bench of the channel slot, setup and sequencing block
`timescale 1ns/1ps
module tb_adc_channel_setup_sequencer;

	logic        clk_sys;
	logic        sys_rst;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        conv_done;
	logic [23:0] conv_raw;
	logic        conv_run;
	logic        cal_internal;
	logic [3:0]  active_slot;
	logic [4:0]  pos_input_sel;
	logic [4:0]  neg_input_sel;
	logic        pos_input_buf_en;
	logic        neg_input_buf_en;
	logic        pos_refin_buf_en;
	logic        neg_refin_buf_en;
	logic [2:0]  gain_select;
	logic        amp_stage1_en;
	logic        amp_stage2_en;
	logic [1:0]  ref_source;
	logic        int_ref_power;
	logic        ref_output_drive;
	logic        bipolar_mode;
	logic [23:0] filter_word;
	logic [23:0] offset_coef;
	logic [23:0] gain_coef;
	logic [23:0] result_data;
	logic        result_valid;
	logic [3:0]  result_slot;
	int          fail_count;
	int          comparisons;
	int          cycles;
	logic [31:0] rd;
	logic        err;

	////////////////////////////////////////////////////////////////////////
	// Device under test with default parameters
	adc_seq_top DUT (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .conv_done(conv_done),
		.conv_raw(conv_raw), .conv_run(conv_run), .cal_internal(cal_internal),
		.active_slot(active_slot), .pos_input_sel(pos_input_sel),
		.neg_input_sel(neg_input_sel), .pos_input_buf_en(pos_input_buf_en),
		.neg_input_buf_en(neg_input_buf_en), .pos_refin_buf_en(pos_refin_buf_en),
		.neg_refin_buf_en(neg_refin_buf_en), .gain_select(gain_select),
		.amp_stage1_en(amp_stage1_en), .amp_stage2_en(amp_stage2_en),
		.ref_source(ref_source), .int_ref_power(int_ref_power),
		.ref_output_drive(ref_output_drive), .bipolar_mode(bipolar_mode),
		.filter_word(filter_word), .offset_coef(offset_coef), .gain_coef(gain_coef),
		.result_data(result_data), .result_valid(result_valid),
		.result_slot(result_slot)
	);

	// Clock of 40 ns period
	initial
	begin
		clk_sys = 1'h0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Hang guard: counts as a mismatch and closes the run
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fail_count++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Comparison, bus and conversion helpers
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// One APB transfer, request held until pready is sampled high
	task apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
		@(posedge clk_sys);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= {idx, 2'h0};
		pwdata  <= wd;
		@(posedge clk_sys);
		penable <= 1'h1;
		// Look at the answer mid-cycle, where it is settled; the hang guard ends a lost wait
		@(negedge clk_sys);
		while (pready !== 1'h1)
			@(negedge clk_sys);
		rd = prdata;
		err = pslverr;
		// Access completes at this edge; release only after it
		@(posedge clk_sys);
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task wr(input logic [5:0] idx, input logic [31:0] wd);
		apb(1'h1, idx, wd);
		repeat (3) @(posedge clk_sys);
		#1;
	endtask : wr

	task rdchk(input string name, input logic [5:0] idx, input logic [31:0] exp);
		apb(1'h0, idx, 32'h0);
		chk(name, rd, exp);
	endtask : rdchk

	// One-cycle conversion pulse; returns just after the answering edge
	task conv(input logic [23:0] raw);
		@(posedge clk_sys);
		conv_done <= 1'h1;
		conv_raw  <= raw;
		@(posedge clk_sys);
		conv_done <= 1'h0;
		#1;
	endtask : conv

	////////////////////////////////////////////////////////////////////////
	// Reset values, refused accesses
	task t_reset_regs();
		rdchk("slot0", adc_seq_pkg::IDX_CHAN_FIRST, 32'h8001);
		rdchk("slot1", adc_seq_pkg::IDX_CHAN_FIRST + 6'h1, 32'h0);
		rdchk("cfg0", adc_seq_pkg::IDX_CFG_FIRST, 32'h0860);
		rdchk("offs0", adc_seq_pkg::IDX_OFFS_FIRST, 32'h800000);
		rdchk("gain7", adc_seq_pkg::IDX_GAIN_FIRST + 6'h7, 32'h500000);
		apb(1'h0, 6'h05, 32'h0);
		chk("unmapped err", err, 32'h1);
		apb(1'h1, adc_seq_pkg::IDX_STATUS, 32'h1f);
		chk("status write err", err, 32'h1);
		chk("run", conv_run, 32'h1);
		chk("neg sel", neg_input_sel, 32'h1);
		chk("filter word", filter_word, 32'h060180);
		chk("gain coef rst", gain_coef, 32'h500000);
	endtask : t_reset_regs

	// Every gain code, buffer forcing and amplifier stages
	task t_gain_buffers();
		logic [2:0] g;
		for (int i = 0; i < 8; i++)
		begin
			g = i[2:0];
			wr(adc_seq_pkg::IDX_CFG_FIRST, {29'h0, g});
			chk("gain", gain_select, {29'h0, g});
			chk("stage1", amp_stage1_en, {31'h0, g != 3'h0});
			chk("stage2", amp_stage2_en, {31'h0, g > 3'h3});
			chk("pos buf", pos_input_buf_en, {31'h0, g != 3'h0});
			chk("neg buf", neg_input_buf_en, {31'h0, g != 3'h0});
		end
		wr(adc_seq_pkg::IDX_CFG_FIRST, 32'h0140);
		chk("pos buf", pos_input_buf_en, 32'h1);
		chk("neg buf", neg_input_buf_en, 32'h0);
		chk("pos ref buf", pos_refin_buf_en, 32'h1);
		chk("neg ref buf", neg_refin_buf_en, 32'h0);
	endtask : t_gain_buffers

	// Reference routing and output coding
	task t_ref_coding();
		logic [1:0] s;
		wr(adc_seq_pkg::IDX_CTRL, 32'h1);
		for (int i = 0; i < 3; i++)
		begin
			s = i[1:0];
			wr(adc_seq_pkg::IDX_CFG_FIRST, {27'h0, s, 3'h0});
			chk("ref src", ref_source, {30'h0, s});
			chk("ref power", int_ref_power, 32'h1);
			chk("ref out", ref_output_drive, {31'h0, s == 2'h2});
		end
		wr(adc_seq_pkg::IDX_CTRL, 32'h0);
		chk("ref power off", int_ref_power, 32'h0);
		chk("ref out off", ref_output_drive, 32'h0);
		wr(adc_seq_pkg::IDX_CFG_FIRST, 32'h0);
		chk("bipolar", bipolar_mode, 32'h0);
		conv(24'h000100);
		chk("valid", result_valid, 32'h1);
		chk("unipolar", result_data, 32'h000200);
		chk("slot repeat", active_slot, 32'h0);
		conv(24'hffff00);
		chk("unipolar clamp", result_data, 32'h0);
		wr(adc_seq_pkg::IDX_CFG_FIRST, 32'h0800);
		conv(24'h0);
		chk("bipolar zero", result_data, 32'h800000);
		rdchk("data reg", adc_seq_pkg::IDX_DATA, 32'h800000);
	endtask : t_ref_coding

	// Ascending wrap over slots 2, 5, 9 sharing setups; slot 0 disabled
	task t_sequence();
		wr(adc_seq_pkg::IDX_OFFS_FIRST + 6'h2, 32'h123456);
		wr(adc_seq_pkg::IDX_CHAN_FIRST + 6'h2, 32'h9064);
		wr(adc_seq_pkg::IDX_CHAN_FIRST + 6'h5, 32'ha0c7);
		wr(adc_seq_pkg::IDX_CHAN_FIRST + 6'h9, 32'h91e0);
		wr(adc_seq_pkg::IDX_CHAN_FIRST, 32'h0);
		conv(24'h0);
		chk("skip valid", result_valid, 32'h0);
		chk("slot a", active_slot, 32'h2);
		chk("pos a", pos_input_sel, 32'h3);
		chk("neg a", neg_input_sel, 32'h4);
		conv(24'h0);
		chk("res slot a", result_slot, 32'h2);
		chk("res a", result_data, 32'h800000);
		chk("slot b", active_slot, 32'h5);
		chk("offs b", offset_coef, 32'h123456);
		conv(24'h0);
		chk("res slot b", result_slot, 32'h5);
		chk("res b", result_data, 32'hedcbaa);
		chk("slot c", active_slot, 32'h9);
		chk("pos c", pos_input_sel, 32'hf);
		chk("offs c", offset_coef, 32'h800000);
		conv(24'h0);
		chk("res slot c", result_slot, 32'h9);
		chk("wrap", active_slot, 32'h2);
	endtask : t_sequence

	// Zero and full scale calibration, all four modes, on the active slot's setup
	task t_calibration();
		wr(adc_seq_pkg::IDX_CTRL, 32'h08);
		chk("cal int", cal_internal, 32'h1);
		conv(24'h000010);
		repeat (2) @(posedge clk_sys);
		rdchk("cal offs", adc_seq_pkg::IDX_OFFS_FIRST + 6'h1, 32'h800010);
		rdchk("other offs", adc_seq_pkg::IDX_OFFS_FIRST + 6'h2, 32'h123456);
		rdchk("idle mode", adc_seq_pkg::IDX_CTRL, 32'h04);
		rdchk("status", adc_seq_pkg::IDX_STATUS, 32'h02);
		wr(adc_seq_pkg::IDX_CTRL, 32'h14);
		chk("cal sys", cal_internal, 32'h0);
		conv(24'h000020);
		repeat (2) @(posedge clk_sys);
		rdchk("cal gain", adc_seq_pkg::IDX_GAIN_FIRST + 6'h1, 32'h000010);
		rdchk("kept gain", adc_seq_pkg::IDX_GAIN_FIRST, 32'h500000);
		chk("slot kept", active_slot, 32'h2);
		chk("gain coef", gain_coef, 32'h000010);
		wr(adc_seq_pkg::IDX_CTRL, 32'h10);
		chk("zcal sys", cal_internal, 32'h0);
		conv(24'h000030);
		chk("sys offs", offset_coef, 32'h800030);
		wr(adc_seq_pkg::IDX_CTRL, 32'h0c);
		chk("fcal int", cal_internal, 32'h1);
		conv(24'h000050);
		chk("int gain", gain_coef, 32'h000020);
		chk("run idle", conv_run, 32'h0);
	endtask : t_calibration

	////////////////////////////////////////////////////////////////////////
	// Report and verdict
	task end_of_test();
		$display("Checks %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test

	// Main sequence
	initial
	begin
		fail_count = 0;
		comparisons = 0;
		cycles = 0;
		sys_rst = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		conv_done = 1'h0;
		conv_raw = 24'h0;
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'h0;
		t_reset_regs();
		t_gain_buffers();
		t_ref_coding();
		t_sequence();
		t_calibration();
		end_of_test();
	end

endmodule : tb_adc_channel_setup_sequencer
